// >>> verilog/tds_pkg.sv
package tds_pkg;
  // soft symbol: 6-bit sign-magnitude, bit 5 is the sign
  localparam int SOFT_W = 6;
  localparam int SOFT_SIGN_BIT = 5;
  localparam logic [5:0] SOFT_MAX_POS = 6'h1f; // +31
  localparam logic [5:0] SOFT_DEAD_NEG = 6'h20; // -0, same bin as 0
  localparam logic [5:0] SOFT_MAX_NEG = 6'h3f; // -31
  // one symbol is an i/q pair, four symbols form one group
  localparam int SYM_W = 2 * SOFT_W;
  localparam int N_SYM = 4;
  localparam int WORD_W = N_SYM * SYM_W;
  // counter and alignment widths
  localparam int CNT_W = 8;
  localparam int ALIGN_W = 2;
  localparam logic [7:0] CNT_ZERO = 8'h00;
  localparam logic [7:0] CNT_ONE = 8'h01;
  localparam logic [7:0] CNT_MAX = 8'hff;
  localparam logic [1:0] ALIGN_RST = 2'h0;
  localparam logic [1:0] ALIGN_ONE = 2'h1;
  // buffer depth between alignment and the trellis datapath
  localparam int FIFO_DEPTH = 32;
  // monitor modes: counting a period, or sitting out a settle period
  typedef enum logic {TDS_COUNT, TDS_SETTLE} tds_mode_t;
endpackage

// >>> verilog/tds_sync.sv

// buffer between the aligner and the trellis datapath
module tds_fifo #(
  parameter int WIDTH = 48,
  parameter int DEPTH = 32
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [WIDTH-1:0] wr_data,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [WIDTH-1:0] rd_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH]; // storage, not reset
  logic [AW:0] wp_r, wp_nxt; // write pointer with wrap bit
  logic [AW:0] rp_r, rp_nxt; // read pointer with wrap bit
  logic do_wr, do_rd;
  logic full, empty;

  // full when pointers differ only in the wrap bit
  assign full = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
  assign empty = (wp_r == rp_r);
  assign wr_ready = !full;
  assign rd_valid = !empty;
  assign rd_data = mem[rp_r[AW-1:0]];
  // transfers only happen on enabled edges
  assign do_wr = ce && wr_valid && !full;
  assign do_rd = ce && rd_ready && !empty;

  // pointer next values
  always_comb begin
    wp_nxt = wp_r;
    rp_nxt = rp_r;
    if (sys_rst) begin
      wp_nxt = '0;
      rp_nxt = '0;
    end else begin
      if (do_wr) wp_nxt = wp_r + 1'b1;
      if (do_rd) rp_nxt = rp_r + 1'b1;
    end
  end

  // pointer registers
  always_ff @(posedge ref_clk) begin
    wp_r <= wp_nxt;
    rp_r <= rp_nxt;
  end

  // memory write; a reset edge writes nothing
  always_ff @(posedge ref_clk) begin
    if (do_wr && !sys_rst) mem[wp_r[AW-1:0]] <= wr_data;
  end
endmodule

// symbol alignment and normalisation monitor
module tds_sync
  import tds_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [SOFT_W-1:0] soft_inphase_0,
  input wire logic [SOFT_W-1:0] soft_quadrature_0,
  input wire logic [SOFT_W-1:0] soft_inphase_1,
  input wire logic [SOFT_W-1:0] soft_quadrature_1,
  input wire logic [SOFT_W-1:0] soft_inphase_2,
  input wire logic [SOFT_W-1:0] soft_quadrature_2,
  input wire logic [SOFT_W-1:0] soft_inphase_3,
  input wire logic [SOFT_W-1:0] soft_quadrature_3,
  input wire logic norm_event,
  input wire logic [CNT_W-1:0] norm_threshold,
  input wire logic [CNT_W-1:0] metric_window_len,
  input wire logic auto_align_enable,
  output logic window_strobe,
  output logic resync_pulse,
  output logic [ALIGN_W-1:0] align_state,
  output logic out_valid,
  input wire logic out_ready,
  output logic [SOFT_W-1:0] out_inphase_0,
  output logic [SOFT_W-1:0] out_quadrature_0,
  output logic [SOFT_W-1:0] out_inphase_1,
  output logic [SOFT_W-1:0] out_quadrature_1,
  output logic [SOFT_W-1:0] out_inphase_2,
  output logic [SOFT_W-1:0] out_quadrature_2,
  output logic [SOFT_W-1:0] out_inphase_3,
  output logic [SOFT_W-1:0] out_quadrature_3
);
  logic [WORD_W-1:0] cur_word; // group now at the inputs
  logic [WORD_W-1:0] prev_r, prev_nxt; // last accepted group
  logic [2*WORD_W-1:0] seq; // prev then cur, oldest symbol lowest
  logic [WORD_W-1:0] al_word; // group pushed into the buffer
  logic [WORD_W-1:0] rd_word;
  logic push;
  tds_mode_t mode_r, mode_nxt; // monitor mode
  logic [CNT_W-1:0] per_r, per_nxt; // cycles elapsed in period
  logic [CNT_W-1:0] ncnt_r, ncnt_nxt; // normalisations this period
  logic [CNT_W-1:0] ncnt_inc;
  logic [ALIGN_W-1:0] al_r, al_nxt; // alignment state
  logic stb_r, stb_nxt; // window strobe register
  logic rsy_r, rsy_nxt; // resync pulse register
  logic per_end, hit;

  // symbols are carried raw; sign-magnitude codes pass untouched
  assign cur_word = {soft_inphase_3, soft_quadrature_3,
                     soft_inphase_2, soft_quadrature_2,
                     soft_inphase_1, soft_quadrature_1,
                     soft_inphase_0, soft_quadrature_0};
  assign seq = {cur_word, prev_r};

  // shift by al_r symbols: the lowest al_r outputs come from the
  // previous group, i.e. those symbols are delayed by one group
  always_comb begin
    al_word = cur_word; // unshifted when alignment is off
    if (auto_align_enable) begin
      al_word = seq[(N_SYM - int'(al_r)) * SYM_W +: WORD_W];
    end // else align state ignored
  end

  assign push = ce && in_valid && in_ready;

  // previous group register next value
  always_comb begin
    prev_nxt = prev_r;
    if (sys_rst) prev_nxt = '0;
    else if (push) prev_nxt = cur_word;
  end

  always_ff @(posedge ref_clk) begin
    prev_r <= prev_nxt;
  end

  // buffer stalls the source through in_ready when it fills
  tds_fifo #(.WIDTH(WORD_W), .DEPTH(DEPTH)) u_fifo (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .wr_valid(ce && in_valid),
    .wr_ready(in_ready),
    .wr_data(al_word),
    .rd_valid(out_valid),
    .rd_ready(out_ready),
    .rd_data(rd_word)
  );

  assign {out_inphase_3, out_quadrature_3,
          out_inphase_2, out_quadrature_2,
          out_inphase_1, out_quadrature_1,
          out_inphase_0, out_quadrature_0} = rd_word;

  // monitor: saturating count so a long period cannot wrap past 255
  assign ncnt_inc = (ncnt_r == CNT_MAX) ? ncnt_r : ncnt_r + CNT_ONE;
  // len 0 behaves as 256 cycles since len - 1 wraps to 255
  assign per_end = (per_r == metric_window_len - CNT_ONE);

  // monitor next values; runs regardless of auto_align_enable
  always_comb begin
    mode_nxt = mode_r;
    per_nxt = per_r;
    ncnt_nxt = ncnt_r;
    al_nxt = al_r;
    // pulses hold with ce low, like every other flip-flop
    stb_nxt = stb_r;
    rsy_nxt = rsy_r;
    hit = 1'b0;
    if (sys_rst) begin
      mode_nxt = TDS_COUNT;
      per_nxt = CNT_ZERO;
      ncnt_nxt = CNT_ZERO;
      al_nxt = ALIGN_RST;
      stb_nxt = 1'b0;
      rsy_nxt = 1'b0;
    end else if (ce) begin
      // a pulse lasts one enabled clock; downstream must qualify with ce
      stb_nxt = 1'b0;
      rsy_nxt = 1'b0;
      case (mode_r)
        TDS_COUNT: begin
          // events arrive at most every other enabled cycle
          if (norm_event) ncnt_nxt = ncnt_inc;
          hit = norm_event && (ncnt_inc > norm_threshold);
          per_nxt = per_r + CNT_ONE;
          if (hit) begin
            stb_nxt = 1'b1;
            rsy_nxt = 1'b1;
            al_nxt = al_r + ALIGN_ONE;
            mode_nxt = TDS_SETTLE;
            per_nxt = CNT_ZERO;
            ncnt_nxt = CNT_ZERO;
          end else if (per_end) begin
            stb_nxt = 1'b1;
            per_nxt = CNT_ZERO;
            ncnt_nxt = CNT_ZERO;
          end
        end
        TDS_SETTLE: begin
          // counter disabled while the decoder settles
          per_nxt = per_r + CNT_ONE;
          if (per_end) begin
            mode_nxt = TDS_COUNT;
            per_nxt = CNT_ZERO;
            ncnt_nxt = CNT_ZERO;
          end
        end
        default: mode_nxt = TDS_COUNT;
      endcase
    end
  end

  // monitor registers
  always_ff @(posedge ref_clk) begin
    mode_r <= mode_nxt;
    per_r <= per_nxt;
    ncnt_r <= ncnt_nxt;
    al_r <= al_nxt;
    stb_r <= stb_nxt;
    rsy_r <= rsy_nxt;
  end

  assign window_strobe = stb_r;
  assign resync_pulse = rsy_r;
  assign align_state = al_r;

  a_resync_strobe: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    resync_pulse |-> window_strobe) else $error("resync without strobe");
  a_pulse_once: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    resync_pulse && ce |=> !resync_pulse)
    else $error("resync longer than one");
  a_align_step: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    $rose(resync_pulse) |-> al_r == $past(al_r) + ALIGN_ONE)
    else $error("align state did not step");
  a_hold_disabled: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    !ce |=> $stable(al_r) && $stable(per_r) && $stable(ncnt_r)
    && $stable(window_strobe) && $stable(resync_pulse))
    else $error("state moved with enable low");
  a_reset_clear: assert property (
    @(posedge ref_clk)
    sys_rst |=> per_r == CNT_ZERO && al_r == ALIGN_RST && !window_strobe)
    else $error("reset did not clear");
  a_settle_quiet: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    resync_pulse |-> mode_r == TDS_SETTLE && ncnt_r == CNT_ZERO)
    else $error("no settle after resync");
  a_period_end: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    ce && mode_r == TDS_COUNT && per_end && !hit
    |=> window_strobe && !resync_pulse && per_r == CNT_ZERO)
    else $error("period end mishandled");
  a_bypass_data: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    push && !auto_align_enable |-> al_word == cur_word)
    else $error("inputs shifted while align off");
  a_hit_count: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    $rose(resync_pulse) |-> $past(ncnt_r) >= $past(norm_threshold))
    else $error("resync below threshold");
endmodule

// >>> verification/tds_demod.sv
// demodulator stand-in: offers one symbol group at a time
module tds_demod (
  input wire logic ref_clk,
  input wire logic ce,
  input wire logic go,
  input wire logic in_ready,
  input wire logic [47:0] rnd,
  output logic in_valid,
  output logic [47:0] grp
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    in_valid = 1'b0;
    grp = 48'h0;
  end
  // a group is held until taken; idle data toggles so stale values never pass
  always @(posedge ref_clk) begin
    if (!in_valid || (ce && in_ready)) begin
      #1 in_valid = go;
      // any 6-bit code is legal; lane 0 q acts as a 4-bit source
      grp = go ? {rnd[47:2], 2'b10} : ~grp;
    end
  end
endmodule

// >>> verification/test_trellis_decoder_symbol_sync.sv
module test_trellis_decoder_symbol_sync
  import tds_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, sys_rst, ce, go, out_ready, norm_event, auto_align_enable;
  logic in_valid, in_ready, out_valid, window_strobe, resync_pulse, le;
  logic [7:0] th, len, cnt, per, c; // stimulus and monitor model
  logic [1:0] align_state, al;
  logic settle;
  logic pce; // ce as sampled at the last rising edge
  logic [34:0] lastp; // pulse expectation last taken off the queue
  logic [15:0] r;
  logic [47:0] rnd, grp, prv;
  wire [47:0] outw;
  logic [47:0] dq[$]; // expected groups, oldest first
  logic [34:0] sq[$]; // expected pulses: {cycle, resync, state}
  int n_mismatch, tests_run, cyc;
  tds_demod src_u (.ref_clk(ref_clk), .ce(ce), .go(go), .in_ready(in_ready),
    .rnd(rnd), .in_valid(in_valid), .grp(grp));
  tds_sync dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .ce(ce),
    .in_valid(in_valid), .in_ready(in_ready),
    .soft_inphase_0(grp[11:6]), .soft_quadrature_0(grp[5:0]),
    .soft_inphase_1(grp[23:18]), .soft_quadrature_1(grp[17:12]),
    .soft_inphase_2(grp[35:30]), .soft_quadrature_2(grp[29:24]),
    .soft_inphase_3(grp[47:42]), .soft_quadrature_3(grp[41:36]),
    .norm_event(norm_event), .norm_threshold(th), .metric_window_len(len),
    .auto_align_enable(auto_align_enable), .window_strobe(window_strobe),
    .resync_pulse(resync_pulse), .align_state(align_state),
    .out_valid(out_valid), .out_ready(out_ready),
    .out_inphase_0(outw[11:6]), .out_quadrature_0(outw[5:0]),
    .out_inphase_1(outw[23:18]), .out_quadrature_1(outw[17:12]),
    .out_inphase_2(outw[35:30]), .out_quadrature_2(outw[29:24]),
    .out_inphase_3(outw[47:42]), .out_quadrature_3(outw[41:36]));
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  // state s: first s symbols come from the tail of the previous group
  function automatic logic [47:0] algn(input logic [47:0] a, p,
                                       input logic [1:0] s, input logic en);
    logic [95:0] w;
    w = {a, p};
    return en ? w[12 * (4 - s) +: 48] : a;
  endfunction
  task automatic chk(input logic [47:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL %0t saw %h expected %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // m: force ce, force go, force ready, allow ready, force event
  task automatic phase(input string nm, input int n, input logic [7:0] t, l,
                       input logic en, input logic [4:0] m);
    @(posedge ref_clk);
    #1 th = t;
    len = l;
    auto_align_enable = en;
    repeat (n) begin
      @(posedge ref_clk);
      #1 r = lfsr(r);
      if (ce) le = norm_event;
      ce = r[0] | m[0];
      go = r[1] | m[1];
      out_ready = (r[2] | m[2]) & m[3];
      norm_event = !le && (r[3] | m[4]);
      rnd = {r, lfsr(r), ~r};
    end
    $display("test %s done", nm);
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // reference monitor and stream model, evaluated on the sampling edge
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    pce = ce;
    if (cyc > 5000) begin
      n_mismatch++;
      print_verdict();
    end
    if (sys_rst) begin
      {cnt, per, settle, al, prv} = '0;
      dq.delete();
      sq.delete();
    end else if (ce) begin
      if (in_valid && in_ready) begin
        dq.push_back(algn(grp, prv, al, auto_align_enable));
        prv = grp;
      end
      c = (cnt == 8'hff) ? cnt : cnt + {7'h0, norm_event};
      if (settle) begin
        settle = (per != len - 8'h01);
        per = settle ? per + 8'h01 : 8'h00;
      end else if (norm_event && c > th) begin
        al = al + 2'h1;
        sq.push_back({cyc + 1, 1'b1, al});
        {settle, per, cnt} = {1'b1, 16'h0};
      end else if (per == len - 8'h01) begin
        sq.push_back({cyc + 1, 1'b0, al});
        {per, cnt} = 16'h0;
      end else begin
        per = per + 8'h01;
        cnt = c;
      end
    end
  end
  // output watchers: stream heads on the edge, pulses and flags between
  always @(posedge ref_clk) begin
    if (!sys_rst && ce && out_valid === 1'b1 && out_ready)
      chk(outw, dq.pop_front());
  end
  always @(negedge ref_clk) begin
    chk({out_valid, in_ready, align_state},
        {dq.size() != 0, dq.size() < 32, al});
    if (window_strobe === 1'b1 && pce !== 1'b1) begin
      // last edge was disabled: the earlier pulse must simply stand
      chk({resync_pulse, align_state}, lastp[2:0]);
    end else if (window_strobe === 1'b1) begin
      if (sq.size() == 0) chk(1, 0);
      else begin
        lastp = sq.pop_front();
        chk({cyc, resync_pulse, align_state}, lastp);
      end
    end else begin
      chk(resync_pulse, 1'b0);
    end
  end
  initial begin
    {sys_rst, ce, go, out_ready, norm_event, auto_align_enable} = 6'b100000;
    {th, len, rnd, le, cyc} = '0;
    r = 16'h001d;
    repeat (2) @(posedge ref_clk);
    #1 sys_rst = 1'b0;
    phase("plain", 300, 8'h03, 8'h08, 1'b0, 5'b01000);
    phase("fill", 60, 8'hff, 8'h00, 1'b0, 5'b00011);
    chk({out_valid, in_ready, dq.size() == 32}, 3'b101);
    phase("align", 400, 8'h00, 8'h04, 1'b1, 5'b11001);
    phase("window", 300, 8'hff, 8'h05, 1'b1, 5'b01000);
    // user thresholds: 20 per 128 cycles, 26 for the rotated set
    phase("rate", 300, 8'h14, 8'h80, 1'b0, 5'b01001);
    phase("rotated", 300, 8'h1a, 8'h80, 1'b1, 5'b01001);
    // reset while disabled still clears every register except the buffer storage
    @(posedge ref_clk);
    #1 {sys_rst, ce} = 2'b10;
    repeat (2) @(posedge ref_clk);
    #1 sys_rst = 1'b0;
    phase("after", 300, 8'h02, 8'h03, 1'b1, 5'b01000);
    phase("drain", 100, 8'hff, 8'h08, 1'b0, 5'b01101);
    print_verdict();
  end
endmodule
